// ### hdl/ts_pkg.sv
`default_nettype none
package ts_pkg;
    // ==========================================
    // Clock and timing
    localparam int CLK_MHZ = 100;
    localparam int CONV_PERIOD_MS = 500;
    localparam int CONV_CYC = CONV_PERIOD_MS * CLK_MHZ * 1000;
    localparam int CONV_CNT_W = 26;
    localparam int TIMEOUT_MS = 25;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_MHZ * 1000;
    localparam int TO_CNT_W = 22;
    // ==========================================
    // Addressing and pointer values
    localparam logic [2:0] ADDR_FIXED = 3'h4;
    localparam logic [7:0] PTR_TEMP = 8'h00;
    localparam logic [7:0] PTR_CFG = 8'h01;
    localparam logic [7:0] PTR_HIGH = 8'h02;
    localparam logic [7:0] PTR_LOW = 8'h03;
    localparam logic [7:0] PTR_HYST = 8'h04;
    localparam logic [7:0] PTR_RST = 8'h00;
    // ==========================================
    // Field layout
    localparam int TEMP_W = 13;
    localparam int CFG_SHDN_BIT = 0;
    localparam int CFG_FQ_BIT = 3;
    localparam int CFG_TO_DIS_BIT = 7;
    localparam logic [15:0] THR_MASK = 16'hfff8;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // ==========================================
    // Reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [15:0] HIGH_RST = 16'h5000;
    localparam logic [15:0] LOW_RST = 16'h0000;
    localparam logic [15:0] HYST_RST = 16'h4b00;
    localparam logic [TEMP_W-1:0] TEMP_RST = 13'h0000;
    // ==========================================
    // Bus states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK
    } ts_state_t;
endpackage
`default_nettype wire

// ### hdl/ts_conv_if.sv
`default_nettype none
interface ts_conv_if;
    import ts_pkg::*;
    logic shutdown;
    logic update;
    logic [TEMP_W-1:0] temp;
    modport conv (input shutdown, output update, output temp);
    modport core (output shutdown, input update, input temp);
endinterface
`default_nettype wire

// ### hdl/ts_sync.sv
`default_nettype none
module ts_sync #(
    parameter int W = 1
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    // ==========================================
    // Two flops per bit
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            always_comb
            begin
                nxt_meta[g] = i_async[g];
                nxt_sync[g] = meta_ff[g];
            end

            always_ff @(posedge i_sys_clk or negedge i_rst_b)
            begin
                if (!i_rst_b)
                begin
                    meta_ff[g] <= 1'b1;
                    sync_ff[g] <= 1'b1;
                end
                else
                begin
                    meta_ff[g] <= nxt_meta[g];
                    sync_ff[g] <= nxt_sync[g];
                end
            end
        end
    endgenerate

    assign o_sync = sync_ff;
endmodule
`default_nettype wire

// ### hdl/ts_conv.sv
`default_nettype none
module ts_conv
    import ts_pkg::*;
#(
    parameter int CYC = CONV_CYC
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic [TEMP_W-1:0] i_adc_code,
    ts_conv_if.conv cif
);
    // ==========================================
    // Free running conversion timer
    localparam logic [CONV_CNT_W-1:0] LAST = CONV_CNT_W'(CYC - 1);

    logic [CONV_CNT_W-1:0] cnt_ff;
    logic [CONV_CNT_W-1:0] nxt_cnt;
    logic [TEMP_W-1:0] result_ff;
    logic [TEMP_W-1:0] nxt_result;
    logic update_ff;
    logic nxt_update;

    always_comb
    begin
        nxt_cnt = (cnt_ff == LAST) ? '0 : CONV_CNT_W'(cnt_ff + 1);
        nxt_update = (cnt_ff == LAST) && !cif.shutdown;
        nxt_result = nxt_update ? i_adc_code : result_ff;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_ff <= '0;
            result_ff <= TEMP_RST;
            update_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            result_ff <= nxt_result;
            update_ff <= nxt_update;
        end
    end

    assign cif.update = update_ff;
    assign cif.temp = result_ff;

    // ==========================================
    // Checks
    a_conv_period: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (cnt_ff == LAST && !cif.shutdown) |=> (update_ff && result_ff == $past(i_adc_code)))
        else $error("conversion result not taken at period end");
    a_shdn_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        cif.shutdown |=> (!update_ff && $stable(result_ff)))
        else $error("conversion ran during shutdown");
endmodule
`default_nettype wire

// ### hdl/ts_smbus_top.sv
`default_nettype none
// Contract
// - Convert continuously, newest result always readable
// - Slave only: byte and word reads, writes
// - Each strap pin gives one address bit
// - Four straps give sixteen distinct addresses
// - First written byte loads register pointer
// - Temperature word 16 bits, read only, low bits
// - Two's complement, one sixteenth degree per step
// - Config: timeout disable, shutdown; fault queue bit 3 stored but unused
// - Threshold variant selects five registers
// - Threshold variant: two status flags, bit two unused
// - Data line only pulled low or released
// - Alarm outputs are open drain
module ts_smbus_top
    import ts_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC,
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter bit THRESH_EN = 1'b1,
    parameter logic [2:0] ADDR_HIGH = ADDR_FIXED
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_b,
    input wire logic i_addr_strap_bit0,
    input wire logic i_addr_strap_bit1,
    input wire logic i_addr_strap_bit2,
    input wire logic i_addr_strap_bit3,
    input wire logic [TEMP_W-1:0] i_adc_code,
    output logic o_alert_out,
    output logic o_alert_oe_b,
    output logic o_overheat_shutdown_out,
    output logic o_overheat_shutdown_oe_b
);
    localparam logic [TO_CNT_W-1:0] TO_LAST = TO_CNT_W'(TIMEOUT_CYCLES - 1);

    // ==========================================
    // Pin synchronisers and conversion engine
    logic [5:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic [3:0] strap_s;
    logic [6:0] my_addr;

    ts_sync #(.W(6)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_addr_strap_bit3, i_addr_strap_bit2, i_addr_strap_bit1,
                  i_addr_strap_bit0, i_sda, i_scl}),
        .o_sync(pins_s)
    );

    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign strap_s = pins_s[5:2];
    assign my_addr = {ADDR_HIGH, strap_s};

    ts_conv_if cif ();

    ts_conv #(.CYC(CONV_CYCLES)) u_conv (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_adc_code(i_adc_code),
        .cif(cif)
    );

    // ==========================================
    // Edge detection and bus timeout
    logic scl_d_ff;
    logic sda_d_ff;
    logic [TO_CNT_W-1:0] to_cnt_ff;
    logic nxt_scl_d;
    logic nxt_sda_d;
    logic [TO_CNT_W-1:0] nxt_to_cnt;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic timeout;
    ts_state_t state_ff;
    logic [7:0] cfg_ff;

    always_comb
    begin
        nxt_scl_d = scl_s;
        nxt_sda_d = sda_s;
        if (state_ff != ST_IDLE && !scl_s && to_cnt_ff != TO_LAST)
            nxt_to_cnt = TO_CNT_W'(to_cnt_ff + 1);
        else if (state_ff != ST_IDLE && !scl_s)
            nxt_to_cnt = to_cnt_ff;
        else
            nxt_to_cnt = '0;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            to_cnt_ff <= '0;
        end
        else
        begin
            scl_d_ff <= nxt_scl_d;
            sda_d_ff <= nxt_sda_d;
            to_cnt_ff <= nxt_to_cnt;
        end
    end

    assign scl_rise = scl_s && !scl_d_ff;
    assign scl_fall = !scl_s && scl_d_ff;
    assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
    assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;
    assign timeout = (to_cnt_ff == TO_LAST) && !cfg_ff[CFG_TO_DIS_BIT];

    // ==========================================
    // Register read view
    logic hi_flag_ff;
    logic lo_flag_ff;
    logic [15:0] high_ff;
    logic [15:0] low_ff;
    logic [15:0] hyst_ff;
    logic [15:0] temp_word;
    logic [15:0] rd_word;
    logic [7:0] ptr_ff;

    always_comb
    begin
        if (THRESH_EN)
            temp_word = {cif.temp, 1'b0, hi_flag_ff, lo_flag_ff};
        else
            temp_word = {cif.temp, 3'h0};
        case (ptr_ff)
            PTR_TEMP: rd_word = temp_word;
            PTR_CFG: rd_word = {cfg_ff, cfg_ff};
            PTR_HIGH: rd_word = THRESH_EN ? high_ff : 16'h0000;
            PTR_LOW: rd_word = THRESH_EN ? low_ff : 16'h0000;
            PTR_HYST: rd_word = THRESH_EN ? hyst_ff : 16'h0000;
            default: rd_word = 16'h0000;
        endcase
    end

    assign cif.shutdown = cfg_ff[CFG_SHDN_BIT];

    // ==========================================
    // Slave state machine
    ts_state_t nxt_state;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic [7:0] tx_ff;
    logic [7:0] nxt_tx;
    logic sda_rel_ff;
    logic nxt_sda_rel;
    logic rw_ff;
    logic nxt_rw;
    logic [7:0] nxt_ptr;
    logic [1:0] bidx_ff;
    logic [1:0] nxt_bidx;
    logic [7:0] msb_ff;
    logic [7:0] nxt_msb;
    logic mack_ff;
    logic nxt_mack;
    logic [7:0] nxt_cfg;
    logic [15:0] nxt_high;
    logic [15:0] nxt_low;
    logic [15:0] nxt_hyst;
    logic byte_end;

    assign byte_end = scl_fall && (cnt_ff == BITS_PER_BYTE);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_shift = shift_ff;
        nxt_tx = tx_ff;
        nxt_sda_rel = sda_rel_ff;
        nxt_rw = rw_ff;
        nxt_ptr = ptr_ff;
        nxt_bidx = bidx_ff;
        nxt_msb = msb_ff;
        nxt_mack = mack_ff;
        nxt_cfg = cfg_ff;
        nxt_high = high_ff;
        nxt_low = low_ff;
        nxt_hyst = hyst_ff;
        if (start_det)
        begin
            nxt_state = ST_ADDR;
            nxt_cnt = 4'h0;
            nxt_sda_rel = 1'b1;
        end
        else if (stop_det || timeout)
        begin
            nxt_state = ST_IDLE;
            nxt_sda_rel = 1'b1;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                begin
                    nxt_sda_rel = 1'b1;
                end
                ST_ADDR, ST_CMD, ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        nxt_shift = {shift_ff[6:0], sda_s};
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                    if (byte_end && state_ff == ST_ADDR)
                    begin
                        if (shift_ff[7:1] == my_addr)
                        begin
                            nxt_sda_rel = 1'b0;
                            nxt_rw = shift_ff[0];
                            nxt_state = ST_ADDR_ACK;
                        end
                        else
                            nxt_state = ST_IDLE;
                    end
                    else if (byte_end && state_ff == ST_CMD)
                    begin
                        nxt_ptr = shift_ff;
                        nxt_sda_rel = 1'b0;
                        nxt_state = ST_CMD_ACK;
                    end
                    else if (byte_end)
                    begin
                        if (ptr_ff == PTR_CFG && bidx_ff == 2'h0)
                            nxt_cfg = shift_ff;
                        if (bidx_ff == 2'h0)
                            nxt_msb = shift_ff;
                        if (THRESH_EN && bidx_ff == 2'h1 && ptr_ff == PTR_HIGH)
                            nxt_high = {msb_ff, shift_ff} & THR_MASK;
                        if (THRESH_EN && bidx_ff == 2'h1 && ptr_ff == PTR_LOW)
                            nxt_low = {msb_ff, shift_ff} & THR_MASK;
                        if (THRESH_EN && bidx_ff == 2'h1 && ptr_ff == PTR_HYST)
                            nxt_hyst = {msb_ff, shift_ff} & THR_MASK;
                        if (bidx_ff != 2'h2)
                            nxt_bidx = bidx_ff + 2'h1;
                        nxt_sda_rel = 1'b0;
                        nxt_state = ST_WDATA_ACK;
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_cnt = 4'h0;
                        nxt_bidx = 2'h0;
                        if (rw_ff)
                        begin
                            nxt_tx = rd_word[15:8];
                            nxt_sda_rel = rd_word[15];
                            nxt_state = ST_RDATA;
                        end
                        else
                        begin
                            nxt_sda_rel = 1'b1;
                            nxt_state = ST_CMD;
                        end
                    end
                end
                ST_CMD_ACK, ST_WDATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_cnt = 4'h0;
                        nxt_sda_rel = 1'b1;
                        nxt_state = ST_WDATA;
                        if (state_ff == ST_CMD_ACK)
                            nxt_bidx = 2'h0;
                    end
                end
                ST_RDATA:
                begin
                    if (scl_rise)
                        nxt_cnt = cnt_ff + 4'h1;
                    if (byte_end)
                    begin
                        nxt_sda_rel = 1'b1;
                        nxt_state = ST_RACK;
                    end
                    else if (scl_fall)
                    begin
                        nxt_tx = {tx_ff[6:0], 1'b1};
                        nxt_sda_rel = tx_ff[6];
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                        nxt_mack = !sda_s;
                    if (scl_fall && mack_ff)
                    begin
                        nxt_tx = rd_word[7:0];
                        nxt_sda_rel = rd_word[7];
                        nxt_cnt = 4'h0;
                        nxt_state = ST_RDATA;
                    end
                    else if (scl_fall)
                        nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            tx_ff <= 8'h00;
            sda_rel_ff <= 1'b1;
            rw_ff <= 1'b0;
            ptr_ff <= PTR_RST;
            bidx_ff <= 2'h0;
            msb_ff <= 8'h00;
            mack_ff <= 1'b0;
            cfg_ff <= CFG_RST;
            high_ff <= HIGH_RST;
            low_ff <= LOW_RST;
            hyst_ff <= HYST_RST;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            shift_ff <= nxt_shift;
            tx_ff <= nxt_tx;
            sda_rel_ff <= nxt_sda_rel;
            rw_ff <= nxt_rw;
            ptr_ff <= nxt_ptr;
            bidx_ff <= nxt_bidx;
            msb_ff <= nxt_msb;
            mack_ff <= nxt_mack;
            cfg_ff <= nxt_cfg;
            high_ff <= nxt_high;
            low_ff <= nxt_low;
            hyst_ff <= nxt_hyst;
        end
    end

    assign o_sda_out = 1'b0;
    assign o_sda_oe_b = sda_rel_ff;

    // ==========================================
    // Alarm flags and open-drain outputs
    logic nxt_hi_flag;
    logic nxt_lo_flag;
    logic overheat_shutdown_out_b_ff;
    logic nxt_overheat_shutdown_out_b;
    logic alert_b_ff;
    logic nxt_alert_b;

    always_comb
    begin
        nxt_hi_flag = hi_flag_ff;
        nxt_lo_flag = lo_flag_ff;
        nxt_overheat_shutdown_out_b = overheat_shutdown_out_b_ff;
        if (THRESH_EN && cif.update)
        begin
            nxt_hi_flag = $signed(cif.temp) >= $signed(high_ff[15:3]);
            nxt_lo_flag = $signed(cif.temp) < $signed(low_ff[15:3]);
            if ($signed(cif.temp) >= $signed(high_ff[15:3]))
                nxt_overheat_shutdown_out_b = 1'b0;
            else if ($signed(cif.temp) < $signed(hyst_ff[15:3]))
                nxt_overheat_shutdown_out_b = 1'b1;
        end
        nxt_alert_b = !(nxt_hi_flag || nxt_lo_flag);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            hi_flag_ff <= 1'b0;
            lo_flag_ff <= 1'b0;
            overheat_shutdown_out_b_ff <= 1'b1;
            alert_b_ff <= 1'b1;
        end
        else
        begin
            hi_flag_ff <= nxt_hi_flag;
            lo_flag_ff <= nxt_lo_flag;
            overheat_shutdown_out_b_ff <= nxt_overheat_shutdown_out_b;
            alert_b_ff <= nxt_alert_b;
        end
    end

    assign o_alert_out = 1'b0;
    assign o_alert_oe_b = alert_b_ff;
    assign o_overheat_shutdown_out = 1'b0;
    assign o_overheat_shutdown_oe_b = overheat_shutdown_out_b_ff;

    // ==========================================
    // Checks
    a_addr_ack: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_ff == ST_ADDR && byte_end && !start_det && !stop_det && !timeout
         && shift_ff[7:1] == {ADDR_HIGH, strap_s}) |=> (state_ff == ST_ADDR_ACK && !o_sda_oe_b))
        else $error("own address not acknowledged");
    a_addr_nack: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_ff == ST_ADDR && byte_end && !start_det && shift_ff[7:1] != my_addr)
        |=> (state_ff == ST_IDLE && o_sda_oe_b))
        else $error("foreign address acknowledged");
    a_ack_origin: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_ff == ST_ADDR_ACK && $past(state_ff) != ST_ADDR_ACK) |-> $past(state_ff) == ST_ADDR)
        else $error("address ack without address phase");
    a_ptr_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_ff == ST_CMD && byte_end && !start_det && !stop_det && !timeout)
        |=> (ptr_ff == $past(shift_ff) && state_ff == ST_CMD_ACK))
        else $error("pointer not loaded from command byte");
    a_cfg_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (state_ff == ST_WDATA && byte_end && !start_det && !stop_det && !timeout
         && ptr_ff == PTR_CFG && bidx_ff == 2'h0) |=> cfg_ff == $past(shift_ff))
        else $error("configuration write lost");
    a_temp_lsbs: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        THRESH_EN ? (temp_word[2] == 1'b0 && temp_word[1:0] == {hi_flag_ff, lo_flag_ff})
                  : (temp_word[2:0] == 3'h0))
        else $error("temperature low bits wrong");
    a_temp_field: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        cif.update |-> ##1 (ptr_ff != PTR_TEMP || rd_word[15:3] == $past(cif.temp, 1) || cif.update))
        else $error("temperature field not the latest result");
    a_sda_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !o_sda_oe_b |-> (o_sda_out == 1'b0 && state_ff inside {ST_ADDR_ACK, ST_CMD_ACK,
                                                               ST_WDATA_ACK, ST_RDATA}))
        else $error("data line driven outside ack or read data");
    a_alert_od: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (o_alert_out == 1'b0 && (o_alert_oe_b == !(hi_flag_ff || lo_flag_ff))))
        else $error("alert output not open drain of flags");
    a_thr_sel: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (THRESH_EN && ptr_ff == PTR_HYST) |-> rd_word == hyst_ff)
        else $error("hysteresis register not selected");
endmodule
`default_nettype wire

// ### verif/ts_smb_host.sv
`default_nettype none
module ts_smb_host (
    input wire logic i_sys_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 12;
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    // ==========
    // Bus master framing, also used as repeated start
    task automatic start();
        o_sda = 1'b1;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        o_sda = 1'b0;
        tick(HALF);
        o_scl = 1'b0;
        tick(2);
    endtask
    task automatic stop();
        o_sda = 1'b0;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        o_sda = 1'b1;
        tick(HALF);
    endtask
    // One byte then acknowledge bit; a 1 releases the line
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] q, output logic ack);
        logic [8:0] sh;
        logic [8:0] r;
        sh = {d, last};
        for (int i = 0; i < 9; i++)
        begin
            o_sda = sh[8];
            sh = sh << 1;
            tick(HALF);
            o_scl = 1'b1;
            tick(HALF);
            r = {r[7:0], i_sda};
            o_scl = 1'b0;
            tick(2);
        end
        q = r[8:1];
        ack = ~r[0];
    endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import ts_pkg::*;
    localparam int CONV = 200;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic scl, host_sda, sda_oe_b, sda_out, alert_oe_b, alert_out, ovt_out, ovt_oe_b;
    logic [3:0] strap = 4'h0;
    logic [TEMP_W-1:0] adc = 13'h0000;
    int cyc = 0;
    int failures = 0;
    int num_checks = 0;
    wire logic sda = host_sda & sda_oe_b;
    always #5 i_sys_clk = ~i_sys_clk;
    ts_smb_host i_host (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda(host_sda));
    ts_smbus_top #(.CONV_CYCLES(CONV), .TIMEOUT_CYCLES(500)) i_dut (
        .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe_b(sda_oe_b),
        .i_addr_strap_bit0(strap[0]), .i_addr_strap_bit1(strap[1]),
        .i_addr_strap_bit2(strap[2]), .i_addr_strap_bit3(strap[3]),
        .i_adc_code(adc), .o_alert_out(alert_out), .o_alert_oe_b(alert_oe_b),
        .o_overheat_shutdown_out(ovt_out), .o_overheat_shutdown_oe_b(ovt_oe_b));
    // ==========
    // Compare and report
    task automatic cmp16(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp1(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========
    // Register access
    task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n, output logic ok);
        logic [7:0] q;
        logic a;
        i_host.start();
        i_host.xfer({ADDR_FIXED, strap, 1'b0}, 1'b1, q, ok);
        i_host.xfer(p, 1'b1, q, a);
        if (n > 0) i_host.xfer(d[15:8], 1'b1, q, a);
        if (n > 1) i_host.xfer(d[7:0], 1'b1, q, a);
        i_host.stop();
    endtask
    task automatic rd(input logic [7:0] p, output logic [15:0] d);
        logic [7:0] q;
        logic a;
        i_host.start();
        i_host.xfer({ADDR_FIXED, strap, 1'b0}, 1'b1, q, a);
        i_host.xfer(p, 1'b1, q, a);
        i_host.start();
        i_host.xfer({ADDR_FIXED, strap, 1'b1}, 1'b1, q, a);
        i_host.xfer(8'hff, 1'b0, d[15:8], a);
        i_host.xfer(8'hff, 1'b1, d[7:0], a);
        i_host.stop();
    endtask
    // ==========
    // Scenarios
    task automatic t_addr();
        logic [7:0] q;
        logic a;
        for (int i = 0; i < 16; i += 5)
        begin
            strap = 4'(i);
            i_host.tick(4);
            i_host.start();
            i_host.xfer({ADDR_FIXED, strap, 1'b0}, 1'b1, q, a);
            cmp1("own addr", 1'b1, a);
            i_host.stop();
            i_host.start();
            i_host.xfer({ADDR_FIXED, ~strap, 1'b0}, 1'b1, q, a);
            cmp1("other strap", 1'b0, a);
            i_host.stop();
            i_host.start();
            i_host.xfer({~ADDR_FIXED, strap, 1'b0}, 1'b1, q, a);
            cmp1("fixed bits", 1'b0, a);
            i_host.stop();
        end
    endtask
    task automatic t_regs();
        logic [15:0] d;
        logic a;
        wr(PTR_CFG, 16'h8800, 1, a);
        cmp1("cfg ack", 1'b1, a);
        rd(PTR_CFG, d);
        cmp16("cfg", 16'h8888, d);
        wr(PTR_CFG, 16'h0000, 1, a);
        adc = 13'h0190;
        i_host.tick(2 * CONV + 5);
        rd(PTR_TEMP, d);
        cmp16("temp pos", 16'h0c80, d);
        cmp1("alert idle", 1'b1, alert_oe_b);
        cmp1("overheat idle", 1'b1, ovt_oe_b);
        wr(PTR_TEMP, 16'h1234, 2, a);
        rd(PTR_TEMP, d);
        cmp16("temp ro", 16'h0c80, d);
        adc = 13'h1ff0;
        i_host.tick(2 * CONV + 5);
        rd(PTR_TEMP, d);
        cmp16("temp neg", 16'hff81, d);
        cmp1("alert low", 1'b0, alert_oe_b);
        wr(PTR_CFG, 16'h0100, 1, a);
        adc = 13'h0190;
        i_host.tick(2 * CONV + 5);
        rd(PTR_TEMP, d);
        cmp16("temp held", 16'hff81, d);
        wr(PTR_CFG, 16'h0000, 1, a);
        wr(PTR_HIGH, 16'h0c87, 2, a);
        rd(PTR_HIGH, d);
        cmp16("high", 16'h0c80, d);
        rd(PTR_HYST, d);
        cmp16("hyst", 16'h4b00, d);
        rd(PTR_TEMP, d);
        cmp16("temp new", 16'h0c82, d);
        cmp1("alert high", 1'b0, alert_oe_b);
        cmp1("overheat set", 1'b0, ovt_oe_b);
        cmp1("sda out", 1'b0, sda_out);
        cmp1("alert out", 1'b0, alert_out);
        cmp1("overheat out", 1'b0, ovt_out);
    endtask
    task automatic t_timeout();
        logic [7:0] q;
        logic a;
        i_host.start();
        i_host.xfer({ADDR_FIXED, strap, 1'b1}, 1'b1, q, a);
        cmp1("read ack", 1'b1, a);
        i_host.tick(10);
        cmp1("read drive", 1'b0, sda);
        i_host.tick(600);
        cmp1("timeout release", 1'b1, sda);
        i_host.stop();
    endtask
    task automatic t_reset();
        logic [15:0] d;
        i_rst_b = 1'b0;
        i_host.tick(10);
        i_rst_b = 1'b1;
        i_host.tick(5);
        cmp1("alert reset", 1'b1, alert_oe_b);
        cmp1("overheat reset", 1'b1, ovt_oe_b);
        rd(PTR_HIGH, d);
        cmp16("high reset", HIGH_RST, d);
        rd(PTR_CFG, d);
        cmp16("cfg reset", {CFG_RST, CFG_RST}, d);
    endtask
    always @(posedge i_sys_clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            failures++;
            finish_test();
        end
    end
    initial
    begin
        i_host.tick(10);
        i_rst_b = 1'b1;
        i_host.tick(5);
        t_addr();
        t_regs();
        t_timeout();
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire
